// File: logic/led_pwm_consts.svh
// Offsets, field positions, reset values and timing counts for the
// nine-output open-drain PWM intensity generator.
// Assumes an 8-bit address and 8-bit data register port.
`ifndef LED_PWM_CONSTS_SVH
`define LED_PWM_CONSTS_SVH

// Register offsets
`define ADDR_CFG 8'h00
`define ADDR_PHASE0 8'h04
`define ADDR_PHASE1 8'h08
`define ADDR_NINTH_PHASE 8'h0c
`define ADDR_MASTER 8'h10
`define ADDR_INT01 8'h14
`define ADDR_INT23 8'h18
`define ADDR_INT45 8'h1c
`define ADDR_INT67 8'h20
`define ADDR_STEP 8'h24

// Configuration bit positions
`define CFG_GLOBAL_BIT 0
`define CFG_BLINK_EN_BIT 1
`define CFG_BLINK_FLIP_BIT 2

// Ninth output phase register bit positions
`define NINTH_PH0_BIT 0
`define NINTH_PH1_BIT 1

// Reset values
`define CFG_RESET 8'h00
`define PHASE_RESET 8'hff
`define NINTH_PHASE_RESET 2'h3
`define MASTER_RESET 8'h00
`define INT_RESET 8'hff

// Timing
`define CLK_PERIOD_NS 8
`define OSC_PERIOD_NS 31250
`define OSC_DIV (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define PWM_STEPS 240
`define PWM_CYCLES_PER_SLOT 16
`define PWM_SLOTS 15
`define INT_FULL 4'hf

`endif

// File: logic/led_pwm_intensity_global.sv
// Nine-output open-drain PWM intensity generator with global mode.
// Assumes one 125 MHz clock, a synchronous blink input and
// external pull-ups on every port output.
//
// Notes on behaviour
// [R1] Ninth intensity field doubles as global field
// [R2] Global mode only when configuration flag set
// [R3] Global field drives all nine outputs
// [R4] Master plus global nibble form 240-step control
// [R5] Global mode always covers every output
// [R6] Software mixing static and PWM uses individual mode
// [R7] Phase bit 0: low for (n+1)/16
// [R8] Phase bit 1: low for (15-n)/16
// [R9] Setting 0xF gives static level, no modulation
// [R10] Outputs open-drain: pull low or release
// [R11] First eight level bits share one register
// [R12] Ninth level bits live in separate register
// [R13] Period 240 steps, 15 slots of 16
// [R14] Master gates modulation to 1..15 slots
// [R15] Full-scale setting ignores master, static, glitch-free
// [R16] Blink disabled: phase 0 bit sets level
// [R17] Step counter from oscillator, restarts after reset
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "led_pwm_consts.svh"

module led_pwm_intensity_global
    import led_pwm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire reg_req_t req,
    output logic [7:0] rd_data,
    // Blink input pin
    input wire logic blink_in,
    // Open-drain port outputs
    output od_pins_t port_outputs
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] cfg_reg; // Global, blink enable, blink flip
    logic [7:0] phase0_reg; // Phase 0 levels, outputs 0..7
    logic [7:0] phase1_reg; // Phase 1 levels, outputs 0..7
    logic [1:0] ninth_phase_reg; // Ninth output levels, both phases
    logic [7:0] master_reg; // Master high nibble, ninth low nibble
    logic [7:0] int_reg [0:3]; // Two individual nibbles each
    logic [7:0] rd_data_reg; // Read data, one cycle after strobe

    // Register writes, one process for all software state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_reg <= `CFG_RESET;
            phase0_reg <= `PHASE_RESET;
            phase1_reg <= `PHASE_RESET;
            ninth_phase_reg <= `NINTH_PHASE_RESET;
            master_reg <= `MASTER_RESET;
            for (int i = 0; i < 4; i++) begin
                int_reg[i] <= `INT_RESET;
            end
        end else if (req.wr) begin
            case (req.addr)
                `ADDR_CFG: cfg_reg <= req.wdata;
                // Eight levels land in one write, together
                `ADDR_PHASE0: phase0_reg <= req.wdata; // R11
                `ADDR_PHASE1: phase1_reg <= req.wdata; // R11
                // Ninth levels never share a write with the rest
                `ADDR_NINTH_PHASE: ninth_phase_reg <= req.wdata[1:0]; // R12
                `ADDR_MASTER: master_reg <= req.wdata;
                `ADDR_INT01: int_reg[0] <= req.wdata;
                `ADDR_INT23: int_reg[1] <= req.wdata;
                `ADDR_INT45: int_reg[2] <= req.wdata;
                `ADDR_INT67: int_reg[3] <= req.wdata;
                default: ; // Unmapped writes ignored
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator divider and step counter
    logic [11:0] div_reg; // Core cycles within one oscillator tick
    logic tick; // One-cycle enable at the oscillator rate
    logic [7:0] step_reg; // Step within the 240-step period

    assign tick = (div_reg == 12'(`OSC_DIV - 1));

    // Divider stands in for the free-running oscillator
    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_reg <= 12'h000;
        end else if (tick) begin
            div_reg <= 12'h000;
        end else begin
            div_reg <= div_reg + 12'h001;
        end
    end

    // Period restarts at step zero after reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            step_reg <= 8'h00; // R17
        end else if (tick) begin
            if (step_reg == 8'(`PWM_STEPS - 1)) begin
                step_reg <= 8'h00; // R13
            end else begin
                step_reg <= step_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-output level selection
    logic [3:0] slot; // Master timeslot 0..14
    logic [3:0] cycle; // PWM cycle 0..15 within the slot
    logic [3:0] master_int; // Master gate nibble
    logic global_mode; // Global intensity selected
    logic use_phase1; // Blink phase 1 registers in force
    logic [8:0] act_bit; // Selected level bit per output
    logic [3:0] sel_int [0:8]; // Intensity used per output
    logic [8:0] pull_low; // Next open-drain enables

    assign slot = 4'(step_reg / 8'(`PWM_CYCLES_PER_SLOT));
    assign cycle = step_reg[3:0];
    assign master_int = master_reg[7:4];
    assign global_mode = cfg_reg[`CFG_GLOBAL_BIT]; // R2
    // Blink disabled forces the phase 0 registers
    assign use_phase1 = cfg_reg[`CFG_BLINK_EN_BIT]
        & (cfg_reg[`CFG_BLINK_FLIP_BIT] ^ blink_in); // R16
    assign act_bit = use_phase1
        ? {ninth_phase_reg[`NINTH_PH1_BIT], phase1_reg}
        : {ninth_phase_reg[`NINTH_PH0_BIT], phase0_reg};

    // Intensity source: own nibble, or ninth nibble for everyone
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            sel_int[k] = global_mode ? master_reg[3:0] // R1 R3 R5
                : (k[0] ? int_reg[k/2][7:4] : int_reg[k/2][3:0]);
        end
        sel_int[8] = master_reg[3:0]; // R1
    end

    // On-time shows the level bit, off-time its inverse
    always_comb begin
        logic lvl;
        lvl = 1'b1;
        for (int k = 0; k < 9; k++) begin
            if (sel_int[k] == `INT_FULL || master_int == 4'h0) begin
                // Static: full scale or master nibble zero, no PWM edges at all
                lvl = act_bit[k]; // R9 R15
            end else if (slot < master_int
                         && cycle <= sel_int[k]) begin
                // Gated slot, within n+1 cycles of on-time
                lvl = act_bit[k]; // R4 R7 R8 R14
            end else begin
                lvl = ~act_bit[k]; // R7 R8 R14
            end
            // Logic high is released, logic low pulled down
            pull_low[k] = ~lvl; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output and read-back flops
    od_pins_t pins_reg; // Registered pin drive

    // Pins never drive high; the enable alone carries the level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins_reg.out <= 9'h000; // R10
            pins_reg.oe <= 9'h000;
        end else begin
            pins_reg.out <= 9'h000; // R10
            pins_reg.oe <= pull_low;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data_reg <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `ADDR_CFG: rd_data_reg <= cfg_reg;
                `ADDR_PHASE0: rd_data_reg <= phase0_reg;
                `ADDR_PHASE1: rd_data_reg <= phase1_reg;
                `ADDR_NINTH_PHASE: rd_data_reg <= {6'h00, ninth_phase_reg};
                `ADDR_MASTER: rd_data_reg <= master_reg;
                `ADDR_INT01: rd_data_reg <= int_reg[0];
                `ADDR_INT23: rd_data_reg <= int_reg[1];
                `ADDR_INT45: rd_data_reg <= int_reg[2];
                `ADDR_INT67: rd_data_reg <= int_reg[3];
                `ADDR_STEP: rd_data_reg <= step_reg;
                default: rd_data_reg <= 8'h00; // Unmapped reads zero
            endcase
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    assign rd_data = rd_data_reg;
    assign port_outputs = pins_reg;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    step_wrap_a: assert property ( // R13
        @(posedge core_clk) disable iff (reset)
        (tick && step_reg == 8'hef) |=> (step_reg == 8'h00))
        else $error("step counter did not wrap after 240 steps");

    step_range_a: assert property ( // R13
        @(posedge core_clk) disable iff (reset)
        step_reg < 8'hf0)
        else $error("step counter out of range");

    step_restart_a: assert property ( // R17
        @(posedge core_clk) reset |=> (step_reg == 8'h00))
        else $error("period did not restart after reset");

    open_drain_a: assert property ( // R10
        @(posedge core_clk) disable iff (reset)
        port_outputs.out == 9'h000)
        else $error("port output driven high");

    global_source_a: assert property ( // R1
        @(posedge core_clk) disable iff (reset)
        global_mode |-> (sel_int[3] == master_reg[3:0]
                         && sel_int[0] == master_reg[3:0]))
        else $error("global field not used by all outputs");

    global_uniform_a: assert property ( // R3
        @(posedge core_clk) disable iff (reset)
        (global_mode && act_bit == 9'h000)
        |=> (port_outputs.oe == 9'h000 || port_outputs.oe == 9'h1ff))
        else $error("outputs differ in global mode");

    full_static_a: assert property ( // R15
        @(posedge core_clk) disable iff (reset)
        (sel_int[0] == 4'hf)
        |=> (port_outputs.oe[0] == !$past(act_bit[0])))
        else $error("full-scale output not static");

    phase0_on_a: assert property ( // R7
        @(posedge core_clk) disable iff (reset)
        (master_int != 4'h0 && slot < master_int && !act_bit[1]
         && sel_int[1] != 4'hf && cycle <= sel_int[1])
        |=> port_outputs.oe[1])
        else $error("phase 0 on-time not pulled low");

    phase1_on_a: assert property ( // R8
        @(posedge core_clk) disable iff (reset)
        (master_int != 4'h0 && slot < master_int && act_bit[2]
         && sel_int[2] != 4'hf && cycle > sel_int[2])
        |=> port_outputs.oe[2])
        else $error("phase 1 off-time not pulled low");

    gate_off_a: assert property ( // R14
        @(posedge core_clk) disable iff (reset)
        (master_int != 4'h0 && slot >= master_int && !act_bit[4]
         && sel_int[4] != 4'hf)
        |=> !port_outputs.oe[4])
        else $error("output modulated outside gated slots");

    ninth_apart_a: assert property ( // R12
        @(posedge core_clk) disable iff (reset)
        (req.wr && req.addr == `ADDR_PHASE0)
        |=> $stable(ninth_phase_reg))
        else $error("ninth level changed with the other eight");

    blink_off_a: assert property ( // R16
        @(posedge core_clk) disable iff (reset)
        !cfg_reg[`CFG_BLINK_EN_BIT] |-> (act_bit[7:0] == phase0_reg))
        else $error("blink disabled but phase 0 not in force");

endmodule : led_pwm_intensity_global

// File: logic/led_pwm_pkg.sv
// Types shared by the PWM intensity generator and its bench.
// Constants live in led_pwm_consts.svh.
package led_pwm_pkg;

    // One register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Open-drain pin group for the nine outputs
    typedef struct packed {
        logic [8:0] out;
        logic [8:0] oe;
    } od_pins_t;

endpackage : led_pwm_pkg

// File: tb/led_load_model.sv
// Loads on the nine open-drain port outputs, each with a pull-up.
// Assumes the package types of the PWM intensity generator.
`timescale 1ns/10ps

module led_load_model
    import led_pwm_pkg::*;
(
    // Pins as driven by the device
    input wire od_pins_t port_outputs,
    // Wire level seen by each load
    output logic [8:0] pin_level
);
    // Released pin floats up through the pull-up
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            pin_level[i] = port_outputs.oe[i]
                ? port_outputs.out[i] : 1'b1;
        end
    end
endmodule : led_load_model

// File: tb/led_pwm_intensity_global_tb.sv
// Self-checking bench for the nine-output PWM intensity generator.
// Assumes the design, its package, constants header and load model.
`timescale 1ns/10ps
`include "led_pwm_consts.svh"

module led_pwm_intensity_global_tb
    import led_pwm_pkg::*;
;
    // One scenario: register image and blink pin
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] master;
        logic [7:0] ph0;
        logic [7:0] ph1;
        logic [1:0] nph;
        logic blink;
        logic [31:0] ints;
    } row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t req = '0;
    logic [7:0] rd_data;
    logic blink_in = 1'b0;
    od_pins_t port_outputs;
    logic [8:0] pin_level;
    logic [7:0] shadow [0:9]; // Bench copy of the registers
    int cnt = 0; // Cycles since reset release
    int fails = 0;
    int cmp_count = 0;
    row_t rows [0:8];

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) cnt <= reset ? 0 : cnt + 1;

    led_pwm_intensity_global i_led_pwm_intensity_global (
        .core_clk(core_clk), .reset(reset), .req(req), .rd_data(rd_data),
        .blink_in(blink_in), .port_outputs(port_outputs));
    led_load_model i_led_load_model (
        .port_outputs(port_outputs), .pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////
    // Reference: pin levels expected at a given step
    function automatic logic [8:0] exp_pins(int step);
        logic [8:0] lvl;
        logic [8:0] low;
        logic [3:0] n;
        logic [3:0] m;
        m = shadow[4][7:4];
        // Blink selects phase 1 bits when enabled and flip differs
        if (shadow[0][1] & (shadow[0][2] ^ blink_in))
            lvl = {shadow[3][1], shadow[2]};
        else
            lvl = {shadow[3][0], shadow[1]};
        for (int i = 0; i < 9; i++) begin
            n = (shadow[0][0] || i == 8) ? shadow[4][3:0]
                : shadow[5 + i / 2][4 * (i % 2) +: 4];
            if (n == 4'hf || m == 4'h0 || (step / 16 < m && step % 16 <= n))
                low[i] = ~lvl[i];
            else
                low[i] = lvl[i];
        end
        return ~low;
    endfunction : exp_pins

    task automatic check(string what, logic [8:0] exp, logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////
    // Register port, one strobe cycle then idle; a gap keeps drives apart
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req <= '0;
        if (a <= `ADDR_INT67) shadow[a[7:2]] = d;
    endtask : wr_reg

    task automatic rd_reg(logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req <= '0;
        #1 v = rd_data;
    endtask : rd_reg

    // Every register read back against the bench copy
    task automatic regs_check();
        logic [7:0] v;
        for (int i = 0; i < 10; i++) begin
            rd_reg(8'(4 * i), v);
            // Step moves on its own: expect the count at the strobe edge
            if (i == 9) shadow[9] = 8'((cnt - 1) / `OSC_DIV % 240);
            check("register", {1'b0, shadow[i]}, {1'b0, v});
        end
    endtask : regs_check

    // Mid-step sample: far from any step edge or register write
    task automatic check_step();
        logic [7:0] v;
        int k;
        for (k = 0; k < 4000 && cnt % `OSC_DIV != `OSC_DIV / 2; k++) begin
            @(posedge core_clk);
            #1;
        end
        if (k == 4000) begin
            fails++;
            report_and_stop();
        end
        check("pins", exp_pins(cnt / `OSC_DIV % 240), pin_level);
        check("drive data", 9'h000, port_outputs.out);
        rd_reg(`ADDR_STEP, v);
        check("step", 9'(cnt / `OSC_DIV % 240), {1'b0, v});
    endtask : check_step

    task automatic reset_shadow();
        shadow = '{`CFG_RESET, `PHASE_RESET, `PHASE_RESET,
            8'(`NINTH_PHASE_RESET), `MASTER_RESET, `INT_RESET, `INT_RESET,
            `INT_RESET, `INT_RESET, 8'h00};
    endtask : reset_shadow

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] v;
        rows = '{'{8'h00, 8'h10, 8'h00, 8'hff, 2'h0, 1'b0, 32'h76543210},
            '{8'h00, 8'h1e, 8'hff, 8'h00, 2'h3, 1'b0, 32'hfedcb298},
            '{8'h01, 8'h15, 8'h00, 8'h00, 2'h2, 1'b0, 32'h01234567},
            '{8'h01, 8'h07, 8'h5a, 8'h00, 2'h1, 1'b0, 32'h00000000},
            '{8'h03, 8'hf3, 8'h00, 8'h0f, 2'h1, 1'b1, 32'h9abcdef0},
            '{8'h07, 8'h2e, 8'h3c, 8'hff, 2'h2, 1'b1, 32'h13579bdf},
            '{8'h01, 8'h1f, 8'h33, 8'h00, 2'h0, 1'b0, 32'h00000000},
            '{8'h00, 8'h12, 8'h00, 8'h00, 2'h0, 1'b0, 32'hecaf1234},
            '{8'h00, 8'h1a, 8'h0f, 8'h00, 2'h0, 1'b0, 32'h89abcdef}};
        reset_shadow();
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        regs_check();
        check_step();
        // Table of scenarios, two steps each
        for (int r = 0; r < 9; r++) begin
            @(posedge core_clk);
            blink_in <= rows[r].blink;
            wr_reg(`ADDR_CFG, rows[r].cfg);
            wr_reg(`ADDR_MASTER, rows[r].master);
            wr_reg(`ADDR_PHASE0, rows[r].ph0);
            wr_reg(`ADDR_PHASE1, rows[r].ph1);
            wr_reg(`ADDR_NINTH_PHASE, {6'h00, rows[r].nph});
            for (int j = 0; j < 4; j++)
                wr_reg(8'(`ADDR_INT01 + 4 * j), rows[r].ints[8 * j +: 8]);
            check_step();
            check_step();
        end
        // Unmapped and read-only writes change nothing
        wr_reg(8'h30, 8'h5a);
        wr_reg(`ADDR_STEP, 8'h77);
        rd_reg(8'h30, v);
        check("unmapped read", 9'h000, {1'b0, v});
        // A non-zero read first, so stale data would show
        rd_reg(`ADDR_MASTER, v);
        @(posedge core_clk);
        #1 check("idle read data", 9'h000, {1'b0, rd_data});
        regs_check();
        // Second reset in mid-run restarts the period
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1 check("reset drive", 9'h000, port_outputs.oe);
        reset_shadow();
        regs_check();
        check_step();
        report_and_stop();
    end
endmodule : led_pwm_intensity_global_tb
